// >>> dsgp_pkg.sv
// Constants, register map and types for the debug-shared GPIO port
package dsgp_pkg;
  localparam int NPIN = 4;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DATA = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUTEN = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FSEL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OD = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_PU = 8'h2c;
  localparam logic [ADDR_W-1:0] OFS_PD = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_IE = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_STBY = 8'h3c;
  localparam logic [NPIN-1:0] RST_DATA = 4'h0;
  localparam logic [NPIN-1:0] RST_OUTEN = 4'h1;
  localparam logic [NPIN-1:0] RST_FSEL = 4'h3;
  localparam logic [NPIN-1:0] RST_OD = 4'h0;
  localparam logic [NPIN-1:0] RST_PU = 4'h1;
  localparam logic [NPIN-1:0] RST_PD = 4'h2;
  localparam logic [NPIN-1:0] RST_IE = 4'h3;
  localparam logic RST_DRVE = 1'b0;
  localparam int STBY_DRVE_BIT = 0;
  localparam logic [NPIN-1:0] MASK_PU = 4'hd;
  localparam logic [NPIN-1:0] MASK_PD = 4'h2;
  // Pins whose function is serial-wire data or trace output
  localparam logic [NPIN-1:0] DEBUG_DATA_PINS = 4'hd;
  // Pins whose function is an external interrupt input
  localparam logic [NPIN-1:0] EXTINT_PINS = 4'h0;
  localparam int PIN_SWDIO = 0;
  localparam int PIN_SWCLK = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Nine selections need four bits
  typedef enum logic [3:0] {
    SEL_DATA, SEL_OUTEN, SEL_FSEL, SEL_OD, SEL_PU, SEL_PD, SEL_IE,
    SEL_STBY, SEL_NONE
  } dsgp_sel_t;
  typedef struct packed {
    logic [NPIN-1:0] out;
    logic [NPIN-1:0] oe;
    logic [NPIN-1:0] pu;
    logic [NPIN-1:0] pd;
    logic [NPIN-1:0] ie;
  } dsgp_pad_t;
endpackage

// >>> dsgp_port.sv
// Debug-shared 4-pin GPIO port with AXI4-Lite register access
`timescale 1ns/1ps
module dsgp_port
  import dsgp_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_mode,
  input wire logic [NPIN-1:0] pin_in,
  output dsgp_pad_t pad,
  input wire logic dbg_swdio_out,
  input wire logic dbg_swdio_oe,
  output logic dbg_swdio_in,
  output logic dbg_swclk,
  input wire logic trace_clock_out,
  input wire logic trace_data_out,
  input wire logic trace_valid
);

  function automatic dsgp_sel_t decode(input logic [ADDR_W-1:0] a);
    dsgp_sel_t s;
    s = SEL_NONE;
    if (a == OFS_DATA) s = SEL_DATA;
    else if (a == OFS_OUTEN) s = SEL_OUTEN;
    else if (a == OFS_FSEL) s = SEL_FSEL;
    else if (a == OFS_OD) s = SEL_OD;
    else if (a == OFS_PU) s = SEL_PU;
    else if (a == OFS_PD) s = SEL_PD;
    else if (a == OFS_IE) s = SEL_IE;
    else if (a == OFS_STBY) s = SEL_STBY;
    return s;
  endfunction

  logic [NPIN-1:0] data_ff, oe_ff, fsel_ff, od_ff, pu_ff, pd_ff, ie_ff;
  logic drve_ff;
  logic [NPIN-1:0] sync1_ff, sync2_ff;
  dsgp_pad_t pad_ff;
  logic swdio_in_ff, swclk_ff;
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  logic [1:0] bresp_ff, rresp_ff;

  // Write channel: address and data may arrive in either order
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  wire aw_have = aw_got_ff | aw_hs;
  wire w_have = w_got_ff | w_hs;
  wire wr_fire = aw_have & w_have & ~bvalid_ff;
  wire [ADDR_W-1:0] wr_addr = aw_got_ff ? awaddr_ff : s_axi_awaddr;
  wire [31:0] wr_data = w_got_ff ? wdata_ff : s_axi_wdata;
  wire [3:0] wr_strb = w_got_ff ? wstrb_ff : s_axi_wstrb;
  wire dsgp_sel_t wr_sel = decode(wr_addr);
  wire dsgp_sel_t rd_sel = decode(s_axi_araddr);
  wire [NPIN-1:0] wv = wr_data[NPIN-1:0];
  // Only byte lane 0 holds live bits
  wire wr_en = wr_fire & wr_strb[0];

  assign s_axi_awready = ~aw_got_ff & ~bvalid_ff;
  assign s_axi_wready = ~w_got_ff & ~bvalid_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

  // Pin muxing and stop-mode gating
  wire [NPIN-1:0] fun_out = {trace_data_out, trace_clock_out, 1'b0,
                             dbg_swdio_out};
  wire [NPIN-1:0] fun_valid = {trace_valid, trace_valid, 1'b0,
                               dbg_swdio_oe};
  wire gate_on = ~stop_mode | drve_ff;
  wire [NPIN-1:0] keep_out = DEBUG_DATA_PINS & fsel_ff & oe_ff;
  wire [NPIN-1:0] keep_in = EXTINT_PINS & fsel_ff & ie_ff;
  wire [NPIN-1:0] ie_eff = ie_ff & ({NPIN{gate_on}} | keep_in);
  wire [NPIN-1:0] oe_base = oe_ff & (~fsel_ff | fun_valid);
  wire [NPIN-1:0] oe_pre = oe_base & ({NPIN{gate_on}} | keep_out);
  wire [NPIN-1:0] out_val = (fsel_ff & fun_out) | (~fsel_ff & data_ff);
  // Open drain: only a low level is ever driven
  wire [NPIN-1:0] oe_eff = oe_pre & ~(od_ff & out_val);
  wire [NPIN-1:0] in_pass = ie_eff & ~fsel_ff;
  wire [NPIN-1:0] rd_pins = (sync2_ff & in_pass) |
                            (data_ff & ~in_pass);
  dsgp_pad_t nxt_pad;
  assign nxt_pad.out = out_val;
  assign nxt_pad.oe = oe_eff;
  assign nxt_pad.pu = pu_ff;
  assign nxt_pad.pd = pd_ff;
  assign nxt_pad.ie = ie_eff;
  assign pad = pad_ff;
  assign dbg_swdio_in = swdio_in_ff;
  assign dbg_swclk = swclk_ff;

  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (rd_sel)
      SEL_DATA: nxt_rdata[NPIN-1:0] = rd_pins;
      SEL_OUTEN: nxt_rdata[NPIN-1:0] = oe_ff;
      SEL_FSEL: nxt_rdata[NPIN-1:0] = fsel_ff;
      SEL_OD: nxt_rdata[NPIN-1:0] = od_ff;
      SEL_PU: nxt_rdata[NPIN-1:0] = pu_ff;
      SEL_PD: nxt_rdata[NPIN-1:0] = pd_ff;
      SEL_IE: nxt_rdata[NPIN-1:0] = ie_ff;
      SEL_STBY: nxt_rdata[STBY_DRVE_BIT] = drve_ff;
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 4'h0;
      sync2_ff <= 4'h0;
    end else begin
      sync1_ff <= pin_in;
      sync2_ff <= sync1_ff;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_ff <= '0;
      swdio_in_ff <= 1'b0;
      swclk_ff <= 1'b0;
    end else begin
      pad_ff <= nxt_pad;
      // Function inputs see the pin only through the input enable
      swdio_in_ff <= sync2_ff[PIN_SWDIO] & ie_eff[PIN_SWDIO];
      swclk_ff <= sync2_ff[PIN_SWCLK] & ie_eff[PIN_SWCLK];
    end
  end

  // Register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_ff <= RST_DATA;
      oe_ff <= RST_OUTEN;
      fsel_ff <= RST_FSEL;
      od_ff <= RST_OD;
      pu_ff <= RST_PU;
      pd_ff <= RST_PD;
      ie_ff <= RST_IE;
      drve_ff <= RST_DRVE;
    end else if (wr_en) begin
      if (wr_sel == SEL_DATA) data_ff <= wv;
      if (wr_sel == SEL_OUTEN) oe_ff <= wv;
      if (wr_sel == SEL_FSEL) fsel_ff <= wv;
      if (wr_sel == SEL_OD) od_ff <= wv;
      if (wr_sel == SEL_PU) pu_ff <= wv & MASK_PU;
      if (wr_sel == SEL_PD) pd_ff <= wv & MASK_PD;
      if (wr_sel == SEL_IE) ie_ff <= wv;
      if (wr_sel == SEL_STBY) drve_ff <= wr_data[STBY_DRVE_BIT];
    end
  end

  // AXI4-Lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= '0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end else begin
        if (aw_hs) aw_got_ff <= 1'b1;
        if (w_hs) w_got_ff <= 1'b1;
      end
      if (aw_hs) awaddr_ff <= s_axi_awaddr;
      if (w_hs) wdata_ff <= s_axi_wdata;
      if (w_hs) wstrb_ff <= s_axi_wstrb;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rresp_ff <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      rdata_ff <= nxt_rdata;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_reset_release;
    !aresetn ##1 aresetn;
  endsequence

  // Reset must not mask the check of its own release
  property p_reset_debug;
    disable iff (1'b0)
    s_reset_release |-> fsel_ff == 4'h3 && ie_ff == 4'h3 &&
      oe_ff == 4'h1 && pu_ff == 4'h1 && pd_ff == 4'h2;
  endproperty
  a_reset_debug: assert property (p_reset_debug)
    else $error("reset pin configuration wrong");

  property p_ie_gate;
    (ar_hs && rd_sel == SEL_DATA && !ie_ff[2] && !fsel_ff[2])
      |=> s_axi_rdata[2] == $past(data_ff[2]);
  endproperty
  a_ie_gate: assert property (p_ie_gate)
    else $error("input passed without input enable");

  property p_port_drive;
    (!fsel_ff[3] && oe_ff[3] && !od_ff[3] && !stop_mode)
      |=> pad_ff.oe[3] && pad_ff.out[3] == $past(data_ff[3]);
  endproperty
  a_port_drive: assert property (p_port_drive)
    else $error("port pin does not drive its data bit");

  property p_func_route;
    (fsel_ff[0] && oe_ff[0] && dbg_swdio_oe && !od_ff[0])
      |=> pad_ff.out[0] == $past(dbg_swdio_out) && pad_ff.oe[0];
  endproperty
  a_func_route: assert property (p_func_route)
    else $error("SWDIO function not routed to pin");

  property p_open_drain;
    (od_ff & out_val) != '0 |=> (pad_ff.oe & $past(od_ff & out_val)) == '0;
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("open drain pin driven high");

  property p_stop_off;
    (stop_mode && !drve_ff && !fsel_ff[3]) |=> !pad_ff.oe[3] &&
      !pad_ff.ie[3];
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("port pin enabled in stop with drive off");

  property p_stop_on;
    (stop_mode && drve_ff && !fsel_ff[2]) |=>
      pad_ff.ie[2] == $past(ie_ff[2]) &&
      pad_ff.oe[2] == $past(oe_ff[2] && !(od_ff[2] && data_ff[2]));
  endproperty
  a_stop_on: assert property (p_stop_on)
    else $error("stop with drive on altered enables");

  property p_swdio_stop;
    (stop_mode && fsel_ff[0] && oe_ff[0] && dbg_swdio_oe &&
      !(od_ff[0] && dbg_swdio_out)) |=> pad_ff.oe[0];
  endproperty
  a_swdio_stop: assert property (p_swdio_stop)
    else $error("SWDIO output lost in stop");

  property p_trace_stop;
    (stop_mode && !drve_ff && fsel_ff[3] && oe_ff[3] && !od_ff[3])
      |=> pad_ff.oe[3] == $past(trace_valid) && !pad_ff.ie[3];
  endproperty
  a_trace_stop: assert property (p_trace_stop)
    else $error("trace pin stop behaviour wrong");

  sequence s_wr_outen;
    wr_en && wr_sel == SEL_OUTEN;
  endsequence

  property p_write_lands;
    s_wr_outen |=> oe_ff == $past(wv) ##0 s_axi_bvalid;
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("register write did not land with response");

  property p_read_zero;
    ar_hs |=> s_axi_rvalid && s_axi_rdata[31:NPIN] == '0;
  endproperty
  a_read_zero: assert property (p_read_zero)
    else $error("unused read bits not zero");

  property p_pd_mask;
    (wr_en && wr_sel == SEL_PD) |=> pd_ff[0] == 1'b0 &&
      pd_ff[1] == $past(wv[1]);
  endproperty
  a_pd_mask: assert property (p_pd_mask)
    else $error("pull-down register bits wrong");

  property p_pu_mask;
    (wr_en && wr_sel == SEL_PU) |=> pu_ff[1] == 1'b0 &&
      pu_ff[0] == $past(wv[0]);
  endproperty
  a_pu_mask: assert property (p_pu_mask)
    else $error("pull-up register bits wrong");

  property p_bad_wr;
    (wr_fire && wr_sel == SEL_NONE) |=> s_axi_bvalid &&
      s_axi_bresp == RESP_SLVERR;
  endproperty
  a_bad_wr: assert property (p_bad_wr)
    else $error("unmapped write not refused");

  property p_bad_rd;
    (ar_hs && rd_sel == SEL_NONE) |=> s_axi_rdata == 32'h0000_0000;
  endproperty
  a_bad_rd: assert property (p_bad_rd)
    else $error("unmapped read data not zero");

  property p_swdio_in_gate;
    !ie_ff[PIN_SWDIO] |=> !dbg_swdio_in;
  endproperty
  a_swdio_in_gate: assert property (p_swdio_in_gate)
    else $error("SWDIO input passed without input enable");

  property p_swclk_gate;
    !ie_ff[PIN_SWCLK] |=> !dbg_swclk;
  endproperty
  a_swclk_gate: assert property (p_swclk_gate)
    else $error("SWCLK input passed without input enable");

  property p_dbg_in_stop;
    (stop_mode && !drve_ff && fsel_ff[PIN_SWDIO]) |=>
      !pad_ff.ie[PIN_SWDIO] && !dbg_swdio_in;
  endproperty
  a_dbg_in_stop: assert property (p_dbg_in_stop)
    else $error("SWDIO input passed in stop with drive off");

endmodule

// >>> dsgp_pin_model.sv
// Pin-side model: resolves pad drive, external drivers and pulls
`timescale 1ns/1ps
module dsgp_pin_model
  import dsgp_pkg::*;
(
  input wire logic aclk,
  input wire dsgp_pad_t pad,
  input wire logic [NPIN-1:0] ext_lvl,
  input wire logic [NPIN-1:0] ext_en,
  output logic [NPIN-1:0] pin_in
);
  // Undriven, unpulled pins wander rather than hold a stale level
  logic [NPIN-1:0] float_ff = 4'h5;
  // Plain always, so the start value may come from the declaration
  always @(posedge aclk) begin
    float_ff <= ~float_ff;
  end
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      if (pad.oe[i]) begin
        pin_in[i] = pad.out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_lvl[i];
      end else if (pad.pu[i]) begin
        pin_in[i] = 1'b1;
      end else if (pad.pd[i]) begin
        pin_in[i] = 1'b0;
      end else begin
        pin_in[i] = float_ff[i];
      end
    end
  end
endmodule

// >>> dsgp_port_tb.sv
// Self-checking testbench for the debug-shared GPIO port
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dsgp_port_tb;
  import dsgp_pkg::*;
  logic aclk, aresetn, awv, wv, arv, stop_mode;
  logic swd_o, swd_oe, tclk, tdat, tval, awr, wrdy, bv, arr, rv, sdi, sck;
  logic [ADDR_W-1:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [NPIN-1:0] ext_lvl, ext_en, pin_in;
  logic [1:0] br, rr, r;
  dsgp_pad_t pad;
  int n_fail, num_checks, seed;
  logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h28, 8'h2c, 8'h30, 8'h38,
    8'h3c};
  int msk [8] = '{15, 15, 15, 15, 13, 2, 15, 1};
  int mdl [8] = '{0, 1, 3, 0, 1, 2, 3, 0};
  dsgp_port i_dsgp_port (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(1'b1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(1'b1), .stop_mode(stop_mode),
    .pin_in(pin_in), .pad(pad), .dbg_swdio_out(swd_o),
    .dbg_swdio_oe(swd_oe), .dbg_swdio_in(sdi), .dbg_swclk(sck),
    .trace_clock_out(tclk), .trace_data_out(tdat), .trace_valid(tval));
  dsgp_pin_model i_dsgp_pin_model (.aclk(aclk), .pad(pad),
    .ext_lvl(ext_lvl), .ext_en(ext_en), .pin_in(pin_in));
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Responses are held ready, so only valid and payload move here
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
    output logic [1:0] resp);
    bit aw, w, ta, tw, ok;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    aw = 1;
    w = 1;
    while (aw || w) begin
      @(negedge aclk);
      ta = aw && awr;
      tw = w && wrdy;
      @(posedge aclk);
      if (ta) begin
        aw = 0;
        awv <= 1'b0;
      end
      if (tw) begin
        w = 0;
        wv <= 1'b0;
      end
    end
    do begin
      @(negedge aclk);
      ok = bv;
      resp = br;
      @(posedge aclk);
    end while (!ok);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
    output logic [1:0] resp);
    bit ok;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(negedge aclk);
      ok = arr;
      @(posedge aclk);
    end while (!ok);
    arv <= 1'b0;
    do begin
      @(negedge aclk);
      ok = rv;
      v = rdat;
      resp = rr;
      @(posedge aclk);
    end while (!ok);
  endtask
  task automatic wreg(input int i, input int v);
    wr(ofs[i], v, r);
    `CHK("bresp", RESP_OKAY, r)
    mdl[i] = v & msk[i];
  endtask
  task automatic creg(input int i);
    rd(ofs[i], d, r);
    `CHK("rdata", mdl[i], d)
  endtask
  // Pad register, two sync flops and the function-input register
  task automatic wait_pad;
    repeat (4) @(posedge aclk);
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    n_fail++;
    final_report();
  end
  initial begin
    seed = 39;
    {aresetn, awv, wv, arv, awa, ara, wd, stop_mode} = '0;
    {swd_o, swd_oe, tclk, tdat, tval, ext_lvl, ext_en} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    `CHK("pad_pu", 4'h1, pad.pu)
    `CHK("pad_pd", 4'h2, pad.pd)
    `CHK("pad_ie", 4'h3, pad.ie)
    for (int i = 0; i < 8; i++) creg(i);
    $display("reset test done");
    for (int i = 1; i < 8; i++) wreg(i, $random(seed));
    for (int i = 1; i < 8; i++) creg(i);
    wreg(6, 0);
    wreg(0, $random(seed));
    creg(0);
    wr(8'h10, 32'hf, r);
    `CHK("bresp_bad", RESP_SLVERR, r)
    rd(8'h10, d, r);
    `CHK("rresp_bad", RESP_SLVERR, r)
    `CHK("rdata_bad", 32'h0, d)
    $display("register test done");
    wreg(2, 0);
    wreg(3, 0);
    wreg(1, 15);
    wreg(0, 10);
    wait_pad;
    `CHK("pad_out", 4'ha, pad.out)
    `CHK("pad_oe", 4'hf, pad.oe)
    wreg(3, 15);
    wait_pad;
    `CHK("pad_oe_od", 4'h5, pad.oe)
    wreg(3, 0);
    wreg(1, 0);
    wreg(6, 5);
    ext_lvl <= $random(seed);
    ext_en <= 4'hf;
    wait_pad;
    rd(ofs[0], d, r);
    `CHK("data_in", {28'h0, (ext_lvl & 4'h5) | 4'ha}, d)
    `CHK("swdio_in", ext_lvl[0], sdi)
    `CHK("swclk_in", 1'b0, sck)
    $display("port test done");
    wreg(6, 15);
    wreg(1, 15);
    wreg(7, 0);
    stop_mode <= 1'b1;
    wait_pad;
    `CHK("stop_oe", 4'h0, pad.oe)
    `CHK("stop_ie", 4'h0, pad.ie)
    wreg(7, 1);
    wait_pad;
    `CHK("stop_oe", 4'hf, pad.oe)
    `CHK("stop_ie", 4'hf, pad.ie)
    `CHK("swclk_stop", 1'b1, sck)
    wreg(2, 15);
    wreg(7, 0);
    {swd_oe, tval, swd_o, tclk, tdat} <= 5'h1e;
    wait_pad;
    `CHK("dbg_oe", 4'hd, pad.oe)
    `CHK("dbg_ie0", 1'b0, pad.ie[0])
    `CHK("dbg_in0", 1'b0, sdi)
    `CHK("dbg_out", 4'h5, pad.out & 4'hd)
    {swd_oe, tval} <= 2'b00;
    wait_pad;
    `CHK("dbg_oe_off", 4'h0, pad.oe)
    stop_mode <= 1'b0;
    $display("stop test done");
    final_report();
  end
endmodule
